/* File: cpu_status_context_defs.svh */
// register offsets, field positions and reset values for the core status/context bank
// assumes a 32-bit apb slave with word-aligned registers
`ifndef CPU_STATUS_CONTEXT_DEFS_SVH
`define CPU_STATUS_CONTEXT_DEFS_SVH
`define OFS_STATUS      12'h000
`define OFS_CORE_CTRL   12'h004
`define OFS_CONTEXT     12'h008
`define OFS_EVT_STATUS  12'h00C
`define OFS_EVT_CLEAR   12'h010
`define OFS_EVT_ENABLE  12'h014
`define OFS_CORE_EVENT  12'h018
`define SR_PRIO_HI      7
`define SR_PRIO_LO      5
`define SR_REPEAT       4
`define SR_NEG          3
`define SR_OVF          2
`define SR_ZERO         1
`define SR_CARRY        0
`define SR_SA           13
`define SR_SB           12
`define SR_SAB          10
`define CC_EARLY_EXIT   11
`define CC_DEPTH_HI     10
`define CC_DEPTH_LO     8
`define CC_PRIO_TOP     3
`define CC_FRAME        2
`define CC_ROUND        1
`define CC_INT_MODE     0
`define CC_WR_MASK      16'h000F
`define SR_WR_MASK      16'h30EF
`define CTX_RD_MASK     16'h0707
`define EVT_BITS        4
`define REG_RESET       16'h0000
`endif

/* File: cpu_status_context_pkg.sv */
// types for the core status/context register bank
// assumes cpu_status_context_defs.svh is included by the design file
package cpu_status_context_pkg;
  typedef logic [15:0] word_t;
  typedef logic [2:0]  bank_id_t;
  typedef enum logic [1:0] {EXIT_IDLE, EXIT_ARMED, EXIT_DONE} exit_state_t;
  typedef struct packed {
    logic [2:0] prio_low;
    logic       prio_top;
    logic       repeat_active;
    logic       neg;
    logic       ovf;
    logic       zero;
    logic       carry;
    logic       sa;
    logic       sb;
    logic       frame_active;
    logic       round_sel;
    logic       int_mode;
    logic [2:0] depth;
    bank_id_t   cur_bank;
    bank_id_t   man_bank;
    exit_state_t exit_st;
    logic [3:0] evt_status;
    logic [3:0] evt_enable;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        exit_req;
  } state_t;
endpackage : cpu_status_context_pkg

/* File: cpu_status_context_regs.sv */
// core status word, core control word and working-set context status behind apb
// assumes synchronous inputs from the execution unit on clk_i; one-cycle apb answer
`timescale 1ns/10ps
`include "cpu_status_context_defs.svh"

module cpu_status_context_regs
  import cpu_status_context_pkg::*;
(
  input  wire logic        clk_i,          // core clock
  input  wire logic        rst_i,          // sync reset, active high
  input  wire logic        psel_i,         // apb select
  input  wire logic        penable_i,      // apb access phase
  input  wire logic        pwrite_i,       // apb write
  input  wire logic [11:0] paddr_i,        // apb byte address
  input  wire logic [31:0] pwdata_i,       // apb write data
  output logic      [31:0] prdata_o,       // apb read data
  output logic             pready_o,       // apb ready
  output logic             pslverr_o,      // apb error on unmapped address
  input  wire logic        nesting_off_i,  // nesting disabled control
  input  wire logic        flag_upd_i,     // arithmetic result valid
  input  wire logic [15:0] result_i,       // arithmetic result
  input  wire logic        carry_i,        // carry out of msb
  input  wire logic        ovf_i,          // signed overflow
  input  wire logic        zero_upd_i,     // operation affects zero flag
  input  wire logic        repeat_busy_i,  // single-instruction repeat running
  input  wire logic        clip_a_i,       // accumulator a saturated
  input  wire logic        clip_b_i,       // accumulator b saturated
  input  wire logic        do_enter_i,     // do loop entered
  input  wire logic        do_leave_i,     // do loop finished
  input  wire logic        iter_end_i,     // current do iteration finishing
  input  wire logic        prio_wr_i,      // core writes priority (exception entry)
  input  wire logic [3:0]  prio_val_i,     // priority value from core
  input  wire logic        bank_upd_i,     // working set changed
  input  wire logic [2:0]  bank_val_i,     // new working set id
  input  wire logic        manual_swap_i,  // change is a manual swap
  output logic [3:0]       prio_level_o,   // four-bit cpu priority
  output logic             user_int_block_o, // user interrupts blocked
  output logic             do_exit_o,      // end running do loop now
  output logic             frame_full_o,   // frame/stack ptrs span full range
  output logic             round_biased_o, // biased rounding selected
  output logic             mul_integer_o,  // integer multiply mode
  output logic             irq_o           // enabled event pending
);
  import cpu_status_context_pkg::*;

  state_t cur;
  state_t nxt;

  logic  wr_acc;
  logic  rd_acc;
  logic  mapped;
  word_t wd;
  word_t sr_rd;
  word_t cc_rd;
  word_t ctx_rd;
  logic [3:0] evt_set;

  always_comb
  begin
    sr_rd = `REG_RESET;
    sr_rd[`SR_PRIO_HI:`SR_PRIO_LO] = cur.prio_low;
    sr_rd[`SR_REPEAT] = cur.repeat_active;
    sr_rd[`SR_NEG] = cur.neg;
    sr_rd[`SR_OVF] = cur.ovf;
    sr_rd[`SR_ZERO] = cur.zero;
    sr_rd[`SR_CARRY] = cur.carry;
    sr_rd[`SR_SA] = cur.sa;
    sr_rd[`SR_SB] = cur.sb;
    sr_rd[`SR_SAB] = cur.sa | cur.sb;
    cc_rd = `REG_RESET;
    cc_rd[`CC_DEPTH_HI:`CC_DEPTH_LO] = cur.depth;
    cc_rd[`CC_PRIO_TOP] = cur.prio_top;
    cc_rd[`CC_FRAME] = cur.frame_active;
    cc_rd[`CC_ROUND] = cur.round_sel;
    cc_rd[`CC_INT_MODE] = cur.int_mode;
    ctx_rd = {5'h00, cur.cur_bank, 5'h00, cur.man_bank} & `CTX_RD_MASK;
  end

  always_comb
  begin
    nxt = cur;
    wr_acc = psel_i & penable_i & pwrite_i & ~cur.pready;
    rd_acc = psel_i & penable_i & ~pwrite_i & ~cur.pready;
    wd = pwdata_i[15:0];
    mapped = (paddr_i == `OFS_STATUS) || (paddr_i == `OFS_CORE_CTRL) ||
             (paddr_i == `OFS_CONTEXT) || (paddr_i == `OFS_EVT_STATUS) ||
             (paddr_i == `OFS_EVT_CLEAR) || (paddr_i == `OFS_EVT_ENABLE);
    evt_set = 4'h0;
    nxt.pready = psel_i & penable_i & ~cur.pready;
    nxt.pslverr = psel_i & penable_i & ~cur.pready & ~mapped;
    nxt.prdata = 32'h0000_0000;
    if (rd_acc)
    begin
      case (paddr_i)
        `OFS_STATUS:     nxt.prdata = {16'h0000, sr_rd};
        `OFS_CORE_CTRL:  nxt.prdata = {16'h0000, cc_rd};
        `OFS_CONTEXT:    nxt.prdata = {16'h0000, ctx_rd};
        `OFS_EVT_STATUS: nxt.prdata = {28'h0000000, cur.evt_status};
        `OFS_EVT_ENABLE: nxt.prdata = {28'h0000000, cur.evt_enable};
        default:         nxt.prdata = 32'h0000_0000;
      endcase
    end
    // software writes first, hardware updates override
    if (wr_acc && paddr_i == `OFS_STATUS)
    begin
      if (!nesting_off_i)
        nxt.prio_low = wd[`SR_PRIO_HI:`SR_PRIO_LO];
      nxt.neg = wd[`SR_NEG];
      nxt.ovf = wd[`SR_OVF];
      nxt.zero = wd[`SR_ZERO];
      nxt.carry = wd[`SR_CARRY];
      nxt.sa = wd[`SR_SA] & wd[`SR_SAB];
      nxt.sb = wd[`SR_SB] & wd[`SR_SAB];
    end
    if (wr_acc && paddr_i == `OFS_CORE_CTRL)
    begin
      nxt.prio_top = wd[`CC_PRIO_TOP];
      nxt.frame_active = wd[`CC_FRAME];
      nxt.round_sel = wd[`CC_ROUND];
      nxt.int_mode = wd[`CC_INT_MODE];
      if (wd[`CC_EARLY_EXIT] && cur.depth != 3'h0)
        nxt.exit_st = EXIT_ARMED;
    end
    if (wr_acc && paddr_i == `OFS_EVT_ENABLE)
      nxt.evt_enable = pwdata_i[`EVT_BITS-1:0];
    if (wr_acc && paddr_i == `OFS_EVT_CLEAR)
      nxt.evt_status = cur.evt_status & ~pwdata_i[`EVT_BITS-1:0];
    nxt.repeat_active = repeat_busy_i;
    if (flag_upd_i)
    begin
      nxt.neg = result_i[15];
      nxt.ovf = ovf_i;
      nxt.carry = carry_i;
    end
    if (zero_upd_i)
    begin
      if (result_i != 16'h0000)
        nxt.zero = 1'b0;
      else
        nxt.zero = 1'b1;
    end
    if (clip_a_i)
      nxt.sa = 1'b1;
    if (clip_b_i)
      nxt.sb = 1'b1;
    if (prio_wr_i)
    begin
      nxt.prio_low = prio_val_i[2:0];
      nxt.prio_top = prio_val_i[3];
    end
    nxt.exit_req = 1'b0;
    case (cur.exit_st)
      EXIT_IDLE: ;
      EXIT_ARMED:
        if (iter_end_i)
        begin
          nxt.exit_req = 1'b1;
          nxt.exit_st = EXIT_DONE;
          evt_set[0] = 1'b1;
        end
      EXIT_DONE: nxt.exit_st = EXIT_IDLE;
      default: nxt.exit_st = EXIT_IDLE;
    endcase
    if (do_enter_i && !do_leave_i && cur.depth != 3'h7)
      nxt.depth = cur.depth + 3'h1;
    else if (do_leave_i && !do_enter_i && cur.depth != 3'h0)
      nxt.depth = cur.depth - 3'h1;
    if (bank_upd_i)
    begin
      nxt.cur_bank = bank_val_i;
      evt_set[1] = 1'b1;
      if (manual_swap_i)
        nxt.man_bank = bank_val_i;
    end
    evt_set[2] = flag_upd_i & ovf_i;
    evt_set[3] = (clip_a_i & ~cur.sa) | (clip_b_i & ~cur.sb);
    nxt.evt_status = nxt.evt_status | evt_set;      // set wins over clear
    nxt.irq = |(nxt.evt_status & nxt.evt_enable);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur <= '0;
      cur.exit_st <= EXIT_IDLE;
    end
    else
      cur <= nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prio_level_o <= 4'h0;
      user_int_block_o <= 1'b0;
      do_exit_o <= 1'b0;
      frame_full_o <= 1'b0;
      round_biased_o <= 1'b0;
      mul_integer_o <= 1'b0;
    end
    else
    begin
      prio_level_o <= {nxt.prio_top, nxt.prio_low};
      user_int_block_o <= nxt.prio_top | (nxt.prio_low == 3'h7);
      do_exit_o <= nxt.exit_req;
      frame_full_o <= nxt.frame_active;
      round_biased_o <= nxt.round_sel;
      mul_integer_o <= nxt.int_mode;
    end
  end

  assign prdata_o = cur.prdata;
  assign pready_o = cur.pready;
  assign pslverr_o = cur.pslverr;
  assign irq_o = cur.irq;

  // side outputs are registered together with the state, so they track cur in the same cycle
  AST_TOP_BLOCKS: assert property (@(posedge clk_i) disable iff (rst_i)
    cur.prio_top |-> user_int_block_o)
    else $error("top bit did not block");
  AST_LOW_SEVEN: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.prio_low == 3'h7) |-> user_int_block_o)
    else $error("level seven did not block");
  AST_NO_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cur.prio_top && cur.prio_low != 3'h7) |-> !user_int_block_o)
    else $error("interrupts blocked below level seven");
  AST_LEVEL_JOIN: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 prio_level_o == {$past(nxt.prio_top), $past(nxt.prio_low)})
    else $error("priority join wrong");
  AST_PRIO_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    prio_wr_i |=> prio_level_o == $past(prio_val_i))
    else $error("core priority load lost");
  AST_LOCKED_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && paddr_i == `OFS_STATUS && nesting_off_i && !prio_wr_i)
    |=> cur.prio_low == $past(cur.prio_low))
    else $error("priority written while locked");
  AST_OPEN_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && paddr_i == `OFS_STATUS && !nesting_off_i && !prio_wr_i)
    |=> cur.prio_low == $past(pwdata_i[`SR_PRIO_HI:`SR_PRIO_LO]))
    else $error("priority write lost");
  AST_REPEAT: assert property (@(posedge clk_i) disable iff (rst_i)
    repeat_busy_i |=> cur.repeat_active)
    else $error("repeat flag missing");
  AST_REPEAT_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    !repeat_busy_i |=> !cur.repeat_active)
    else $error("repeat flag stuck");
  AST_NEG: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_upd_i && !wr_acc) |=> cur.neg == $past(result_i[15]))
    else $error("neg flag wrong");
  AST_OVF: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_upd_i |=> cur.ovf == $past(ovf_i))
    else $error("ovf flag wrong");
  AST_ZERO_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    (zero_upd_i && result_i != 16'h0000) |=> !cur.zero)
    else $error("zero not cleared");
  AST_ZERO_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    (zero_upd_i && result_i == 16'h0000) |=> cur.zero)
    else $error("zero not set");
  AST_ZERO_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (!zero_upd_i && !wr_acc) |=> cur.zero == $past(cur.zero))
    else $error("zero flag not sticky");
  AST_CARRY: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_upd_i |=> cur.carry == $past(carry_i))
    else $error("carry flag wrong");
  AST_CLIP_OR: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && paddr_i == `OFS_STATUS)
    |=> prdata_o[`SR_SAB] == (prdata_o[`SR_SA] | prdata_o[`SR_SB]))
    else $error("combined clip bit wrong");
  AST_CLIP_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && paddr_i == `OFS_STATUS && !pwdata_i[`SR_SAB] && !clip_a_i && !clip_b_i)
    |=> !cur.sa && !cur.sb)
    else $error("clip flags not cleared by combined bit");
  AST_EXIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.exit_st == EXIT_ARMED && iter_end_i) |=> do_exit_o)
    else $error("early exit lost");
  AST_EXIT_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    do_exit_o |=> !do_exit_o)
    else $error("early exit longer than one cycle");
  AST_NO_EXIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.exit_st == EXIT_IDLE) |=> !do_exit_o)
    else $error("early exit without request");
  AST_EXIT_RD0: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && paddr_i == `OFS_CORE_CTRL) |=> !prdata_o[`CC_EARLY_EXIT])
    else $error("early exit read nonzero");
  AST_DEPTH_UP: assert property (@(posedge clk_i) disable iff (rst_i)
    (do_enter_i && !do_leave_i && cur.depth != 3'h7)
    |=> cur.depth == $past(cur.depth) + 3'h1)
    else $error("do depth not raised");
  AST_DEPTH_DN: assert property (@(posedge clk_i) disable iff (rst_i)
    (do_leave_i && !do_enter_i && cur.depth != 3'h0)
    |=> cur.depth == $past(cur.depth) - 3'h1)
    else $error("do depth not lowered");
  AST_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && paddr_i == `OFS_CORE_CTRL) |=> frame_full_o == $past(pwdata_i[`CC_FRAME]))
    else $error("frame window select wrong");
  AST_ROUND: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && paddr_i == `OFS_CORE_CTRL) |=> round_biased_o == $past(pwdata_i[`CC_ROUND]))
    else $error("rounding select wrong");
  AST_INT_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && paddr_i == `OFS_CORE_CTRL)
    |=> mul_integer_o == $past(pwdata_i[`CC_INT_MODE]))
    else $error("multiply mode wrong");
  AST_BANK: assert property (@(posedge clk_i) disable iff (rst_i)
    bank_upd_i |=> cur.cur_bank == $past(bank_val_i))
    else $error("bank id wrong");
  AST_CTX_RO: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && paddr_i == `OFS_CONTEXT && !bank_upd_i)
    |=> cur.cur_bank == $past(cur.cur_bank) && cur.man_bank == $past(cur.man_bank))
    else $error("context status written by software");
  AST_MANUAL: assert property (@(posedge clk_i) disable iff (rst_i)
    (bank_upd_i && manual_swap_i) |=> cur.man_bank == $past(bank_val_i))
    else $error("manual bank id not loaded");
  AST_MANUAL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !(bank_upd_i && manual_swap_i) |=> cur.man_bank == $past(cur.man_bank))
    else $error("manual bank id changed without swap");
  AST_CTX_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && paddr_i == `OFS_CONTEXT) |=> (prdata_o[15:0] & ~`CTX_RD_MASK) == 16'h0000)
    else $error("context unused bits set");
  // checked through reset, so no disable condition here
  AST_RESET_CLEAR: assert property (@(posedge clk_i)
    rst_i |=> (cur.prio_low == 3'h0 && cur.depth == 3'h0 && prio_level_o == 4'h0))
    else $error("fields not cleared by reset");
  AST_PREADY_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  AST_SLVERR_PAIR: assert property (@(posedge clk_i) disable iff (rst_i)
    pslverr_o |-> pready_o)
    else $error("error without ready");

  COV_EXIT: cover property (@(posedge clk_i) disable iff (rst_i) do_exit_o);
  COV_SWAP: cover property (@(posedge clk_i) disable iff (rst_i) bank_upd_i && manual_swap_i);
  COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
  COV_DEPTH: cover property (@(posedge clk_i) disable iff (rst_i) cur.depth == 3'h2);
  COV_LOCKED: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_acc && paddr_i == `OFS_STATUS && nesting_off_i);
endmodule : cpu_status_context_regs

/* File: tb_top.sv */
// self-checking bench for the core status/context register bank
// assumes a one-cycle apb answer and registered side outputs
`timescale 1ns/10ps
module tb_top;
  import cpu_status_context_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [15:0] w;
    logic        n;
    logic [15:0] r;
    logic [7:0]  p;
  } row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic        nesting_off_i = 1'b0, carry_i = 1'b0, ovf_i = 1'b0;
  logic        repeat_busy_i = 1'b0, manual_swap_i = 1'b0;
  logic [15:0] result_i = 16'h0000;
  logic [3:0]  prio_val_i = 4'h0;
  logic [2:0]  bank_val_i = 3'h0;
  logic [8:0]  pls = 9'h000;
  logic        flag_upd_i, zero_upd_i, clip_a_i, clip_b_i, do_enter_i;
  logic        do_leave_i, iter_end_i, prio_wr_i, bank_upd_i;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, user_int_block_o, do_exit_o, er;
  logic        frame_full_o, round_biased_o, mul_integer_o, irq_o;
  logic [3:0]  prio_level_o;
  int          bad_count = 0, samples_checked = 0, cyc = 0, seen;
  // pulse inputs: 8 flag, 7 zero, 6 clip a, 5 clip b, 4 enter, 3 leave, 2 iter, 1 prio, 0 bank
  assign {flag_upd_i, zero_upd_i, clip_a_i, clip_b_i, do_enter_i} = pls[8:4];
  assign {do_leave_i, iter_end_i, prio_wr_i, bank_upd_i} = pls[3:0];
  // rows run in order: each writes, reads back and checks {prio, block, frame, round, mul}
  row_t rows [9] = '{
    '{12'h000, 16'h00E0, 1'b0, 16'h00E0, 8'h78},
    '{12'h004, 16'h0009, 1'b0, 16'h0009, 8'hF9},
    '{12'h000, 16'h0040, 1'b0, 16'h0040, 8'hA9},
    '{12'h004, 16'h0006, 1'b0, 16'h0006, 8'h26},
    '{12'h000, 16'h00A0, 1'b1, 16'h0040, 8'h26},
    '{12'h008, 16'hFFFF, 1'b0, 16'h0000, 8'h26},
    '{12'h000, 16'hFFFF, 1'b0, 16'h34EF, 8'h7E},
    '{12'h000, 16'h3000, 1'b0, 16'h0000, 8'h06},
    '{12'h004, 16'h0800, 1'b0, 16'h0000, 8'h00}};

  cpu_status_context_regs cpu_status_context_regs_i (
    .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .nesting_off_i, .flag_upd_i, .result_i,
    .carry_i, .ovf_i, .zero_upd_i, .repeat_busy_i, .clip_a_i, .clip_b_i,
    .do_enter_i, .do_leave_i, .iter_end_i, .prio_wr_i, .prio_val_i,
    .bank_upd_i, .bank_val_i, .manual_swap_i, .prio_level_o, .user_int_block_o,
    .do_exit_o, .frame_full_o, .round_biased_o, .mul_integer_o, .irq_o);

  always #2.5 clk_i = ~clk_i;

  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {16'h0000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 16'h0000);
    chk(rd & m, e);
  endtask : rdc

  task automatic pulse(input int i);
    @(posedge clk_i);
    pls[i] <= 1'b1;
    @(posedge clk_i);
    pls[i] <= 1'b0;
  endtask : pulse

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      nesting_off_i <= rows[i].n;
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 16'h0000);
      chk(rd, {16'h0000, rows[i].r});
      chk({24'h0, prio_level_o, user_int_block_o, frame_full_o, round_biased_o,
           mul_integer_o}, {24'h0, rows[i].p});
    end
    result_i <= 16'h8000;
    carry_i <= 1'b1;
    ovf_i <= 1'b1;
    pulse(8);
    rdc(12'h000, 32'hF, 32'hD);
    result_i <= 16'h0000;
    carry_i <= 1'b0;
    ovf_i <= 1'b0;
    pulse(7);
    rdc(12'h000, 32'hF, 32'hF);
    result_i <= 16'h0001;
    pulse(8);
    rdc(12'h000, 32'hF, 32'h2);
    pulse(7);
    rdc(12'h000, 32'hF, 32'h0);
    repeat_busy_i <= 1'b1;
    rdc(12'h000, 32'h10, 32'h10);
    repeat_busy_i <= 1'b0;
    rdc(12'h000, 32'h10, 32'h0);
    pulse(4);
    pulse(4);
    rdc(12'h004, 32'hF00, 32'h200);
    apb(1'b1, 12'h004, 16'h0800);
    rdc(12'h004, 32'h800, 32'h0);
    pulse(2);
    seen = 0;
    repeat (4)
    begin
      @(posedge clk_i);
      seen += int'(do_exit_o === 1'b1);
    end
    chk(seen, 1);
    pulse(3);
    pulse(3);
    rdc(12'h004, 32'hF00, 32'h0);
    bank_val_i <= 3'h2;
    manual_swap_i <= 1'b1;
    pulse(0);
    rdc(12'h008, 32'hFFFFFFFF, 32'h0202);
    bank_val_i <= 3'h1;
    manual_swap_i <= 1'b0;
    pulse(0);
    rdc(12'h008, 32'hFFFFFFFF, 32'h0102);
    prio_val_i <= 4'hB;
    pulse(1);
    rdc(12'h000, 32'hE0, 32'h60);
    chk({27'h0, prio_level_o, user_int_block_o}, 32'h17);
    rdc(12'h00C, 32'hF, 32'h7);
    apb(1'b1, 12'h010, 16'h000F);
    rdc(12'h00C, 32'hF, 32'h0);
    apb(1'b1, 12'h014, 16'h0008);
    pulse(6);
    rdc(12'h000, 32'h3400, 32'h2400);
    chk({31'h0, irq_o}, 32'h1);
    apb(1'b1, 12'h014, 16'h0000);
    rdc(12'h00C, 32'h8, 32'h8);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b1, 12'h014, 16'h0008);
    apb(1'b1, 12'h010, 16'h0008);
    rdc(12'h00C, 32'h8, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b0, 12'h020, 16'h0000);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 12'h004, 16'h000F);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(12'h000, 32'hFFFFFFFF, 32'h0);
    rdc(12'h004, 32'hFFFFFFFF, 32'h0);
    rdc(12'h008, 32'hFFFFFFFF, 32'h0);
    chk({27'h0, prio_level_o, frame_full_o}, 32'h0);
    summarize();
  end
endmodule : tb_top
